// file: verilog/cdf_framer.sv
// Purpose: device end of the configuration download link
// Assumes: uart bytes arrive on the clock domain; host keeps one command open
// Notes:   bad frames get no answer so the host retries
// Contract
// - each good command gets one response
// - packets up to 64 bytes buffered
// - length byte delimits packet contents
// - command: length, sequence, data, checksum
// - response: length, sequence, status, echo, checksum
// - crc-16-ccitt on every frame, checked
// - slip framing around every frame
// - codes end FF, escape FE, FC, FD
// - temporary to ram, permanent also otp
// - no flow control, keep up with bytes (reply bytes still wait on tx_ready)
`timescale 1ns/1ps
`default_nettype none
module cdf_framer
	import cdf_pkg::*;
#(
	parameter int BUF_DEPTH = MAX_PACKET_BYTES
) (
	input  wire logic           clock,
	input  wire logic           sys_rst,
	input  wire cdf_byte_t      rx_in,
	input  wire logic           permanent_mode,
	input  wire logic           tx_ready,
	output cdf_byte_t           tx_out,
	output cdf_cfg_write_t      cfg_out,
	output logic                frame_dropped,
	output logic                busy
);
	function automatic logic [7:0] escape_sub(input logic [7:0] b);
		escape_sub = (b == END_CODE) ? ESCAPED_END_SUB : ESCAPED_ESCAPE_SUB;
	endfunction

	cdf_state_t     state_reg, state_next;
	cdf_tx_t        tx_st_reg, tx_st_next;
	logic [7:0]     buf_reg [BUF_DEPTH];
	logic [6:0]     cnt_reg;
	logic           esc_reg, bad_reg, have_last_reg;
	logic [15:0]    rx_crc_reg, tx_crc_reg, cmd_crc_reg, addr_reg;
	logic [7:0]     last_seq_reg;
	logic [6:0]     ap_idx_reg, ap_end_reg;
	logic [2:0]     ridx_reg;
	cdf_byte_t      tx_reg, tx_next;
	cdf_cfg_write_t cfg_reg;
	logic           drop_reg, busy_reg;
	logic [15:0]    rx_crc_next, tx_crc_next;

	//==============================================================
	// receive decode
	wire        take       = (state_reg == ST_RX) & rx_in.valid;
	wire        is_end     = rx_in.data == END_CODE;
	wire        is_esc     = rx_in.data == FRAME_ESCAPE_CODE;
	wire        sub_ok     = (rx_in.data == ESCAPED_END_SUB) | (rx_in.data == ESCAPED_ESCAPE_SUB);
	wire [7:0]  unesc_byte = (rx_in.data == ESCAPED_END_SUB) ? END_CODE : FRAME_ESCAPE_CODE;
	wire [7:0]  dec_byte   = esc_reg ? unesc_byte : rx_in.data;
	wire        store      = take & ~is_end & (esc_reg | ~is_esc);
	wire        full       = cnt_reg == 7'(BUF_DEPTH);
	wire        store_bad  = store & ((esc_reg & ~sub_ok) | full);
	wire        frame_close = take & is_end & (cnt_reg != 7'h00);
	wire [7:0]  len_expect = 8'(cnt_reg - 7'h01);
	wire        len_ok     = (buf_reg[0] == len_expect) & (cnt_reg >= MIN_FRAME_BYTES);
	wire        crc_ok     = rx_crc_reg == CRC_RESIDUE;
	wire        frame_good = frame_close & ~bad_reg & ~esc_reg & len_ok & crc_ok;
	wire        dup        = have_last_reg & (buf_reg[1] == last_seq_reg);
	wire [15:0] cmd_crc    = {buf_reg[6'(cnt_reg - 7'h02)], buf_reg[6'(cnt_reg - 7'h01)]};

	cdf_crc16 u_rx_crc (
		.crc_in  (rx_crc_reg),
		.data_in (dec_byte),
		.crc_out (rx_crc_next)
	);

	//==============================================================
	// response byte select
	wire        slot      = ~tx_reg.valid | tx_ready;
	wire [7:0]  resp_byte = (ridx_reg == 3'h0) ? RESP_LENGTH :
	                        (ridx_reg == 3'h1) ? last_seq_reg :
	                        (ridx_reg == 3'h2) ? STATUS_OK :
	                        (ridx_reg == 3'h3) ? cmd_crc_reg[15:8] :
	                        (ridx_reg == 3'h4) ? cmd_crc_reg[7:0] :
	                        (ridx_reg == RESP_CRC_INDEX) ? tx_crc_reg[15:8] :
	                        tx_crc_reg[7:0];
	wire        resp_ctrl = (resp_byte == END_CODE) | (resp_byte == FRAME_ESCAPE_CODE);
	wire        advance   = slot & (((tx_st_reg == TX_DATA) & ~resp_ctrl) | (tx_st_reg == TX_SUB));
	wire        apply_wr  = (state_reg == ST_APPLY) & (ap_idx_reg != ap_end_reg);

	cdf_crc16 u_tx_crc (
		.crc_in  (tx_crc_reg),
		.data_in (resp_byte),
		.crc_out (tx_crc_next)
	);

	//==============================================================
	// main sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RX: begin
				if (frame_good) begin
					state_next = dup ? ST_TX : ST_APPLY;
				end
			end
			ST_APPLY: begin
				if (!apply_wr) begin
					state_next = ST_TX;
				end
			end
			ST_TX: begin
				if (tx_st_reg == TX_CLOSE && slot) begin
					state_next = ST_RX;
				end
			end
			default: state_next = ST_RX;
		endcase
	end

	//==============================================================
	// transmit sequence
	always_comb begin
		tx_st_next = tx_st_reg;
		tx_next    = tx_reg;
		if (slot) begin
			tx_next.valid = 1'b0;
		end
		case (tx_st_reg)
			TX_IDLE: begin
				if (state_reg == ST_TX) begin
					tx_st_next = TX_OPEN;
				end
			end
			TX_OPEN: begin
				if (slot) begin
					tx_next    = '{valid: 1'b1, data: END_CODE};
					tx_st_next = TX_DATA;
				end
			end
			TX_DATA: begin
				if (slot && resp_ctrl) begin
					tx_next    = '{valid: 1'b1, data: FRAME_ESCAPE_CODE};
					tx_st_next = TX_SUB;
				end else if (slot) begin
					tx_next    = '{valid: 1'b1, data: resp_byte};
					tx_st_next = (ridx_reg == RESP_LAST_INDEX) ? TX_CLOSE : TX_DATA;
				end
			end
			TX_SUB: begin
				if (slot) begin
					tx_next    = '{valid: 1'b1, data: escape_sub(resp_byte)};
					tx_st_next = (ridx_reg == RESP_LAST_INDEX) ? TX_CLOSE : TX_DATA;
				end
			end
			TX_CLOSE: begin
				if (slot) begin
					tx_next    = '{valid: 1'b1, data: END_CODE};
					tx_st_next = TX_IDLE;
				end
			end
			default: tx_st_next = TX_IDLE;
		endcase
	end

	//==============================================================
	// registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_RX;
			tx_st_reg <= TX_IDLE;
			tx_reg    <= '0;
			drop_reg  <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			tx_st_reg <= tx_st_next;
			tx_reg    <= tx_next;
			drop_reg  <= frame_close & ~frame_good;
			busy_reg  <= state_next != ST_RX;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg    <= 7'h00;
			esc_reg    <= 1'b0;
			bad_reg    <= 1'b0;
			rx_crc_reg <= CRC_INIT;
		end else if (take && is_end) begin
			cnt_reg    <= 7'h00;
			esc_reg    <= 1'b0;
			bad_reg    <= 1'b0;
			rx_crc_reg <= CRC_INIT;
		end else if (take) begin
			esc_reg <= is_esc & ~esc_reg;
			if (store_bad) begin
				bad_reg <= 1'b1;
			end
			if (store && !full) begin
				cnt_reg    <= cnt_reg + 7'h01;
				rx_crc_reg <= rx_crc_next;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (store && !full) begin
			buf_reg[6'(cnt_reg)] <= dec_byte;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			have_last_reg <= 1'b0;
			last_seq_reg  <= 8'h00;
			cmd_crc_reg   <= 16'h0000;
			ap_idx_reg    <= FIRST_DATA_INDEX;
			ap_end_reg    <= FIRST_DATA_INDEX;
		end else if (frame_good && !dup) begin
			have_last_reg <= 1'b1;
			last_seq_reg  <= buf_reg[1];
			cmd_crc_reg   <= cmd_crc;
			ap_idx_reg    <= FIRST_DATA_INDEX;
			ap_end_reg    <= cnt_reg - 7'h02;
		end else if (apply_wr) begin
			ap_idx_reg <= ap_idx_reg + 7'h01;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg  <= '0;
			addr_reg <= 16'h0000;
		end else begin
			cfg_reg.valid <= apply_wr;
			cfg_reg.otp   <= apply_wr & permanent_mode;
			cfg_reg.addr  <= addr_reg;
			cfg_reg.data  <= buf_reg[6'(ap_idx_reg)];
			if (apply_wr) begin
				addr_reg <= addr_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ridx_reg   <= 3'h0;
			tx_crc_reg <= CRC_INIT;
		end else if (tx_st_reg == TX_IDLE) begin
			ridx_reg   <= 3'h0;
			tx_crc_reg <= CRC_INIT;
		end else if (advance) begin
			ridx_reg <= ridx_reg + 3'h1;
			if (ridx_reg < RESP_CRC_INDEX) begin
				tx_crc_reg <= tx_crc_next;
			end
		end
	end

	assign tx_out        = tx_reg;
	assign cfg_out       = cfg_reg;
	assign frame_dropped = drop_reg;
	assign busy          = busy_reg;

	//==============================================================
	// checks
	sequence s_open_slot;
		tx_st_reg == TX_OPEN && slot;
	endsequence
	sequence s_sub_slot;
		tx_st_reg == TX_SUB && slot;
	endsequence

	a_buf_bound: assert property (@(posedge clock) disable iff (sys_rst)
		cnt_reg <= 7'(BUF_DEPTH)) else $error("receive count past buffer");
	a_good_apply: assert property (@(posedge clock) disable iff (sys_rst)
		frame_good && !dup |=> state_reg == ST_APPLY ##0 busy) else $error("good frame not applied");
	a_dup_resend: assert property (@(posedge clock) disable iff (sys_rst)
		frame_good && dup |=> state_reg == ST_TX && !cfg_out.valid [*2]) else $error("dup applied");
	a_bad_drop: assert property (@(posedge clock) disable iff (sys_rst)
		frame_close && !frame_good |=> state_reg == ST_RX && frame_dropped) else $error("bad kept");
	a_open_end: assert property (@(posedge clock) disable iff (sys_rst)
		s_open_slot |=> tx_out.valid && tx_out.data == END_CODE) else $error("no opening end");
	a_escape_pair: assert property (@(posedge clock) disable iff (sys_rst)
		s_sub_slot |-> tx_out.data == FRAME_ESCAPE_CODE ##1 (tx_out.data == ESCAPED_END_SUB
		|| tx_out.data == ESCAPED_ESCAPE_SUB)) else $error("escape without substitute");
	a_cfg_apply: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_out.valid |-> $past(state_reg) == ST_APPLY) else $error("write outside apply");
	a_otp_write: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_out.otp |-> cfg_out.valid && $past(permanent_mode)) else $error("stray otp write");
	a_data_len: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == ST_APPLY |-> ap_end_reg <= 7'd62) else $error("data too long");
endmodule // cdf_framer
`default_nettype wire

// file: inc/cdf_pkg.sv
// Purpose: shared constants and types of the configuration download framer
// Assumes: byte stream comes from a uart on the same clock
// Notes:   crc bytes travel most significant byte first
//==============================================================
// package
package cdf_pkg;
	localparam logic [7:0]  END_CODE            = 8'hFF;
	localparam logic [7:0]  FRAME_ESCAPE_CODE   = 8'hFE;
	localparam logic [7:0]  ESCAPED_END_SUB     = 8'hFC;
	localparam logic [7:0]  ESCAPED_ESCAPE_SUB  = 8'hFD;
	localparam int          MAX_PACKET_BYTES    = 64;
	localparam logic [6:0]  MIN_FRAME_BYTES     = 7'h04;
	localparam logic [6:0]  FIRST_DATA_INDEX    = 7'h02;
	localparam logic [15:0] CRC_INIT            = 16'hFFFF;
	localparam logic [15:0] CRC_POLY            = 16'h1021;
	localparam logic [15:0] CRC_RESIDUE         = 16'h0000;
	localparam logic [7:0]  RESP_LENGTH         = 8'h06;
	localparam logic [7:0]  STATUS_OK           = 8'h00;
	localparam logic [2:0]  RESP_LAST_INDEX     = 3'h6;
	localparam logic [2:0]  RESP_CRC_INDEX      = 3'h5;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} cdf_byte_t;

	typedef struct packed {
		logic        valid;
		logic        otp;
		logic [15:0] addr;
		logic [7:0]  data;
	} cdf_cfg_write_t;

	typedef enum logic [2:0] {
		ST_RX    = 3'b001,
		ST_APPLY = 3'b010,
		ST_TX    = 3'b100
	} cdf_state_t;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_OPEN  = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_SUB   = 5'b01000,
		TX_CLOSE = 5'b10000
	} cdf_tx_t;
endpackage

// file: verilog/cdf_crc16.sv
// Purpose: one byte step of crc-16-ccitt, msb first
// Assumes: caller holds the running value
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module cdf_crc16
	import cdf_pkg::*;
(
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] crc_out
);
	//==============================================================
	// bitwise shift register
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {data_in, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		crc_out = c;
	end
endmodule // cdf_crc16
`default_nettype wire

// file: bench/cdf_host_model.sv
// Purpose: host client model that sends command frames and collects replies
// Assumes: one command open at a time, bytes back to back on rx_in
// Notes:   resp_q holds decoded reply bytes, end_cnt counts frame ends
`timescale 1ns/1ps
`default_nettype none
module cdf_host_model
	import cdf_pkg::*;
(
	input  wire logic      clock,
	input  wire cdf_byte_t tx_out,
	input  wire logic      slow,
	output cdf_byte_t      rx_in,
	output logic           tx_ready
);
	logic [7:0] resp_q[$];
	int         end_cnt = 0;
	logic       esc_reg = 1'b0;
	initial rx_in = '0;
	initial tx_ready = 1'b1;
	//==============================================================
	// command side
	function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
		return c;
	endfunction
	task automatic put(logic [7:0] d);
		@(posedge clock);
		rx_in <= {1'b1, d};
	endtask
	task automatic put_esc(logic [7:0] d);
		if (d == END_CODE || d == FRAME_ESCAPE_CODE) begin
			put(FRAME_ESCAPE_CODE);
			put(d == END_CODE ? ESCAPED_END_SUB : ESCAPED_ESCAPE_SUB);
		end else
			put(d);
	endtask
	task automatic send_cmd(logic [7:0] seq, logic [7:0] data[$], logic [7:0] len_err,
			logic [15:0] crc_err, output logic [15:0] crc);
		logic [7:0] pkt[$];
		pkt = {8'(data.size() + 3) ^ len_err, seq};
		pkt = {pkt, data};
		crc = CRC_INIT;
		foreach (pkt[i])
			crc = crc_byte(crc, pkt[i]);
		pkt = {pkt, crc[15:8] ^ crc_err[15:8], crc[7:0] ^ crc_err[7:0]};
		put(END_CODE);
		foreach (pkt[i])
			put_esc(pkt[i]);
		put(END_CODE);
		@(posedge clock);
		rx_in <= {1'b0, ~rx_in.data};
	endtask
	//==============================================================
	// reply side, optionally stalling
	always @(posedge clock) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_out.valid && tx_ready) begin
			if (tx_out.data == END_CODE)
				end_cnt++;
			else if (esc_reg)
				resp_q.push_back(tx_out.data == ESCAPED_END_SUB ? END_CODE : FRAME_ESCAPE_CODE);
			else if (tx_out.data != FRAME_ESCAPE_CODE)
				resp_q.push_back(tx_out.data);
			esc_reg = !esc_reg && tx_out.data == FRAME_ESCAPE_CODE;
		end
	end
endmodule // cdf_host_model
`default_nettype wire

// file: bench/cdf_framer_tb_top.sv
// Purpose: self-checking bench of the download framer
// Assumes: host model on the uart side, one command at a time
// Notes:   write address runs on across all accepted commands
`timescale 1ns/1ps
`default_nettype none
module cdf_framer_tb_top
	import cdf_pkg::*;
;
	logic           clock = 1'b0;
	logic           sys_rst = 1'b1;
	logic           permanent_mode = 1'b0;
	logic           slow = 1'b0;
	logic           tx_ready;
	logic           frame_dropped;
	logic           busy;
	cdf_byte_t      rx_in;
	cdf_byte_t      tx_out;
	cdf_cfg_write_t cfg_out;
	cdf_cfg_write_t wr_q[$];
	logic [15:0]    next_addr = 16'h0000;
	int             n_mismatch = 0;
	int             checks = 0;
	int             n_drop = 0;
	int             cycles = 0;
	localparam int  RETRY_LIMIT = 3;
	always #12.5 clock = ~clock;
	cdf_framer i_cdf_framer (.clock(clock), .sys_rst(sys_rst), .rx_in(rx_in),
		.permanent_mode(permanent_mode), .tx_ready(tx_ready), .tx_out(tx_out),
		.cfg_out(cfg_out), .frame_dropped(frame_dropped), .busy(busy));
	cdf_host_model i_cdf_host_model (.clock(clock), .tx_out(tx_out), .slow(slow),
		.rx_in(rx_in), .tx_ready(tx_ready));
	//==============================================================
	// monitors and reporting
	always @(posedge clock) begin
		cycles++;
		if (cfg_out.valid === 1'b1)
			wr_q.push_back(cfg_out);
		if (frame_dropped === 1'b1)
			n_drop++;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	//==============================================================
	// one command and its judgement
	task automatic run_cmd(logic [7:0] seq, logic [7:0] d[$], logic [7:0] len_err,
			logic [15:0] crc_err, bit fresh);
		logic [15:0] crc;
		logic [15:0] rc;
		logic [7:0]  exp[$];
		int          drops;
		int          ends;
		bit          bad;
		bad = (len_err != 8'h00) || (crc_err != 16'h0000) || (d.size() + 4 > MAX_PACKET_BYTES);
		drops = n_drop;
		ends = i_cdf_host_model.end_cnt;
		wr_q.delete();
		i_cdf_host_model.resp_q.delete();
		i_cdf_host_model.send_cmd(seq, d, len_err, crc_err, crc);
		repeat (3) @(posedge clock);
		for (int n = 0; n < 800 && busy !== 1'b0; n++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		chk(n_drop - drops, bad);
		chk(wr_q.size(), (bad || !fresh) ? 0 : d.size());
		if (!bad && fresh) begin
			foreach (wr_q[i]) begin
				chk(wr_q[i].addr, next_addr + 16'(i));
				chk(wr_q[i].data, d[i]);
				chk(wr_q[i].otp, permanent_mode);
			end
			next_addr = next_addr + 16'(d.size());
		end
		exp.delete();
		if (!bad)
			exp = {RESP_LENGTH, seq, STATUS_OK, crc[15:8], crc[7:0]};
		rc = CRC_INIT;
		foreach (exp[i])
			rc = i_cdf_host_model.crc_byte(rc, exp[i]);
		if (!bad)
			exp = {exp, rc[15:8], rc[7:0]};
		chk(i_cdf_host_model.end_cnt - ends, bad ? 0 : 2);
		chk(i_cdf_host_model.resp_q.size(), exp.size());
		foreach (exp[i])
			chk(i_cdf_host_model.resp_q[i], exp[i]);
	endtask
	//==============================================================
	// scenarios
	task automatic sc_escape();
		run_cmd(8'h01, '{8'hFF, 8'hFE, 8'hFC, 8'hFD, 8'h12}, 8'h00, 16'h0000, 1);
	endtask
	task automatic sc_duplicate();
		run_cmd(8'h01, '{8'hFF, 8'hFE, 8'hFC, 8'hFD, 8'h12}, 8'h00, 16'h0000, 0);
	endtask
	task automatic sc_bad_crc_retry();
		for (int t = 0; t < RETRY_LIMIT - 1; t++)
			run_cmd(8'h02, '{8'h33, 8'h44}, 8'h00, 16'h0001, 0);
		run_cmd(8'h02, '{8'h33, 8'h44}, 8'h00, 16'h0000, 1);
	endtask
	task automatic sc_bad_length();
		run_cmd(8'h03, '{8'h55}, 8'h01, 16'h0000, 0);
	endtask
	task automatic sc_full_stalled();
		logic [7:0] d[$];
		for (int i = 0; i < 60; i++)
			d.push_back(8'(i * 5 + 8'hC0));
		permanent_mode <= 1'b1;
		slow <= 1'b1;
		run_cmd(8'h04, d, 8'h00, 16'h0000, 1);
		d.push_back(8'h11);
		run_cmd(8'h06, d, 8'h00, 16'h0000, 0);
		permanent_mode <= 1'b0;
		slow <= 1'b0;
	endtask
	task automatic sc_empty();
		logic [7:0] d[$];
		run_cmd(8'h05, d, 8'h00, 16'h0000, 1);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		sc_escape();
		sc_duplicate();
		sc_bad_crc_retry();
		sc_bad_length();
		sc_full_stalled();
		sc_empty();
		test_done();
	end
endmodule // cdf_framer_tb_top
`default_nettype wire
